//--- verilog/nvm_ctrl_map.svh
`ifndef NVM_CTRL_MAP_SVH
`define NVM_CTRL_MAP_SVH

// register indices; byte address is four times the index
`define NVM_IDX_POINTER 12'h81A
`define NVM_IDX_VALUE 12'h81C
`define NVM_IDX_CONTROL 12'h81E
`define NVM_IDX_KEY 12'h81F

// operation_control field positions
`define NVM_BIT_RD 0
`define NVM_BIT_WR 1
`define NVM_BIT_ENABLE 2
`define NVM_BIT_ERROR 3
`define NVM_BIT_FREE 4
`define NVM_BIT_LATCH 5
`define NVM_BIT_REGION 6

// reset values and constants
`define NVM_POINTER_RST 15'h0000
`define NVM_VALUE_RST 14'h0000
`define NVM_LATCH_BLANK 14'h03FF
`define NVM_KEY_FIRST 8'h55
`define NVM_KEY_SECOND 8'hAA
`define NVM_EEPROM_PAGE 7'h70
`define NVM_ROW_WORDS 32

`endif

//--- verilog/nvm_ctrl_pkg.sv
package nvm_ctrl_pkg;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_READ = 5'h02,
    ST_ERASE = 5'h04,
    ST_PROG = 5'h08,
    ST_EEPROM = 5'h10
  } ctrl_state_e;

  typedef enum logic [2:0] {
    KEY_LOCKED = 3'h1,
    KEY_HALF = 3'h2,
    KEY_OPEN = 3'h4
  } key_state_e;

  typedef enum logic [1:0] {
    MEM_READ = 2'h0,
    MEM_ERASE_ROW = 2'h1,
    MEM_PROGRAM_WORD = 2'h2,
    MEM_EEPROM_WRITE = 2'h3
  } mem_op_e;

endpackage : nvm_ctrl_pkg

//--- verilog/nvm_unlock_seq.sv
`timescale 1ns/1ps
`include "nvm_ctrl_map.svh"

module nvm_unlock_seq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic key_write,
  input wire logic [7:0] key_data,
  input wire logic other_write,
  input wire logic control_write,
  input wire logic trigger_write,
  output logic unlocked,
  output logic broken
);

  typedef struct packed {
    nvm_ctrl_pkg::key_state_e step;
    logic broken;
  } unlock_s;

  unlock_s s;
  unlock_s next_s;

  always_comb
  begin
    next_s = s;
    next_s.broken = 1'b0;
    unique case (s.step)
      nvm_ctrl_pkg::KEY_LOCKED:
      begin
        if (key_write && key_data == `NVM_KEY_FIRST)
        begin
          next_s.step = nvm_ctrl_pkg::KEY_HALF;
        end
      end
      nvm_ctrl_pkg::KEY_HALF:
      begin
        if (key_write && key_data == `NVM_KEY_SECOND)
        begin
          next_s.step = nvm_ctrl_pkg::KEY_OPEN;
        end
        else if (key_write || other_write || control_write)
        begin
          next_s.step = nvm_ctrl_pkg::KEY_LOCKED;
          next_s.broken = 1'b1;
        end
      end
      nvm_ctrl_pkg::KEY_OPEN:
      begin
        // the sequence is spent by the very next key, control, pointer or value write
        if (control_write || key_write || other_write)
        begin
          next_s.step = nvm_ctrl_pkg::KEY_LOCKED;
          next_s.broken = !(control_write && trigger_write);
        end
      end
      default:
      begin
        next_s.step = nvm_ctrl_pkg::KEY_LOCKED;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '{step: nvm_ctrl_pkg::KEY_LOCKED, broken: 1'b0};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign unlocked = (s.step == nvm_ctrl_pkg::KEY_OPEN);
  assign broken = s.broken;

endmodule : nvm_unlock_seq

//--- verilog/nvm_write_latches.sv
`timescale 1ns/1ps
`include "nvm_ctrl_map.svh"

module nvm_write_latches #(
  parameter int ROW_WORDS = `NVM_ROW_WORDS,
  parameter int IDX_W = $clog2(ROW_WORDS)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [IDX_W-1:0] load_index,
  input wire logic [13:0] load_data,
  input wire logic blank_all,
  input wire logic [IDX_W-1:0] read_index,
  output logic [13:0] read_data
);

  typedef struct packed {
    logic [ROW_WORDS-1:0][13:0] word;
  } latch_s;

  latch_s s;
  latch_s next_s;

  always_comb
  begin
    next_s = s;
    for (int i = 0; i < ROW_WORDS; i++)
    begin
      if (blank_all)
      begin
        next_s.word[i] = `NVM_LATCH_BLANK;
      end
      else if (load && load_index == IDX_W'(i))
      begin
        next_s.word[i] = load_data;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= {ROW_WORDS{`NVM_LATCH_BLANK}};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign read_data = s.word[read_index];

endmodule : nvm_write_latches

//--- verilog/nvm_write_erase_control.sv
// What this block does
// - protected address on trigger sets error flag, except for a latch-only load
// - reset during busy operation sets error flag
// - broken unlock sequence sets error flag
// - software may set error; only software clears
// - free bit erases whole 32-word row
// - protected erase/program clears trigger, flags error
// - latch-only load copies value into latch
// - row program from latches, then latches blank
// - region bit picks secondary areas or flash
// - enable bit gates program and erase
// - eeprom address triggers single-word erase-program
// - trigger set by software, cleared by hardware
// - 15-bit pointer, top bit shows write active
// - pointer reached as high and low bytes
// - 14-bit value split into byte lanes
// - control bits reset to zero
// - read bit loads value, self-clears
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "nvm_ctrl_map.svh"

module nvm_write_erase_control #(
  parameter int ROW_WORDS = `NVM_ROW_WORDS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_valid,
  output nvm_ctrl_pkg::mem_op_e mem_op,
  output logic mem_region,
  output logic [14:0] mem_addr,
  output logic [13:0] mem_wdata,
  input wire logic mem_ready,
  input wire logic [13:0] mem_rdata,
  input wire logic mem_busy,
  input wire logic write_protected
);

  localparam int IDX_W = $clog2(ROW_WORDS);

  typedef struct packed {
    nvm_ctrl_pkg::ctrl_state_e fsm;
    logic [14:0] pointer;
    logic [13:0] value;
    logic region;
    logic latch_only;
    logic free;
    logic error;
    logic enable;
    logic wr;
    logic rd;
    logic [IDX_W-1:0] index;
    logic mem_valid;
    nvm_ctrl_pkg::mem_op_e mem_op;
    logic after_reset;
    logic [31:0] prdata;
  } ctrl_s;

  ctrl_s s;
  ctrl_s next_s;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic [11:0] index_addr;
  logic hit_pointer;
  logic hit_value;
  logic hit_control;
  logic hit_key;
  logic hit;
  logic access_write;
  logic ctrl_write;
  logic trig_write;
  logic unlocked;
  logic unlock_broken;
  logic latch_load;
  logic latch_blank;
  logic [13:0] latch_word;
  logic eeprom_hit;

  assign index_addr = paddr[13:2];
  assign hit_pointer = (index_addr == `NVM_IDX_POINTER);
  assign hit_value = (index_addr == `NVM_IDX_VALUE);
  assign hit_control = (index_addr == `NVM_IDX_CONTROL);
  assign hit_key = (index_addr == `NVM_IDX_KEY);
  assign hit = hit_pointer || hit_value || hit_control || hit_key;
  assign access_write = psel && penable && pwrite && hit;
  assign ctrl_write = access_write && hit_control && pstrb[0];
  assign trig_write = ctrl_write && pwdata[`NVM_BIT_WR];

  // eeprom window sits at the top of the secondary region
  assign eeprom_hit = s.region && (s.pointer[14:8] == `NVM_EEPROM_PAGE);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  nvm_unlock_seq u_unlock (
    .pclk(pclk),
    .presetn(presetn),
    .key_write(access_write && hit_key && pstrb[0]),
    .key_data(pwdata[7:0]),
    .other_write(access_write && !hit_key && !hit_control),
    .control_write(ctrl_write),
    .trigger_write(trig_write),
    .unlocked(unlocked),
    .broken(unlock_broken)
  );

  nvm_write_latches #(
    .ROW_WORDS(ROW_WORDS),
    .IDX_W(IDX_W)
  ) u_latches (
    .pclk(pclk),
    .presetn(presetn),
    .load(latch_load),
    .load_index(s.pointer[IDX_W-1:0]),
    .load_data(s.value),
    .blank_all(latch_blank),
    .read_index(s.index),
    .read_data(latch_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    logic start;
    logic eeprom_start;
    start = 1'b0;
    // the region bit arrives in the same write as the trigger, so use the written value
    eeprom_start = pwdata[`NVM_BIT_REGION] && (s.pointer[14:8] == `NVM_EEPROM_PAGE);
    next_s = s;
    latch_load = 1'b0;
    latch_blank = 1'b0;
    next_s.after_reset = 1'b0;

    // pointer and value are frozen while an operation is running
    if (access_write && hit_pointer && s.fsm == nvm_ctrl_pkg::ST_IDLE)
    begin
      if (pstrb[0])
      begin
        next_s.pointer[7:0] = pwdata[7:0];
      end
      if (pstrb[1])
      begin
        next_s.pointer[14:8] = pwdata[14:8];
      end
    end
    if (access_write && hit_value && s.fsm == nvm_ctrl_pkg::ST_IDLE)
    begin
      if (pstrb[0])
      begin
        next_s.value[7:0] = pwdata[7:0];
      end
      if (pstrb[1])
      begin
        next_s.value[13:8] = pwdata[13:8];
      end
    end

    if (ctrl_write)
    begin
      next_s.error = pwdata[`NVM_BIT_ERROR];
      if (s.fsm == nvm_ctrl_pkg::ST_IDLE)
      begin
        next_s.region = pwdata[`NVM_BIT_REGION];
        next_s.latch_only = pwdata[`NVM_BIT_LATCH];
        next_s.free = pwdata[`NVM_BIT_FREE];
        next_s.enable = pwdata[`NVM_BIT_ENABLE];
        // read bit is set-only; a busy controller ignores it
        if (pwdata[`NVM_BIT_RD] && !pwdata[`NVM_BIT_WR])
        begin
          next_s.rd = 1'b1;
          next_s.fsm = nvm_ctrl_pkg::ST_READ;
          next_s.mem_valid = 1'b1;
          next_s.mem_op = nvm_ctrl_pkg::MEM_READ;
        end
        // trigger only after the key sequence, and only with enable set
        start = trig_write && unlocked && pwdata[`NVM_BIT_ENABLE];
      end
    end

    if (start)
    begin
      if (!eeprom_start && !pwdata[`NVM_BIT_FREE] && pwdata[`NVM_BIT_LATCH])
      begin
        // latch load completes at once, no protection check
        latch_load = 1'b1;
      end
      else if (write_protected)
      begin
        next_s.error = 1'b1;
      end
      else if (eeprom_start)
      begin
        next_s.wr = 1'b1;
        next_s.fsm = nvm_ctrl_pkg::ST_EEPROM;
        next_s.mem_valid = 1'b1;
        next_s.mem_op = nvm_ctrl_pkg::MEM_EEPROM_WRITE;
      end
      else if (pwdata[`NVM_BIT_FREE])
      begin
        next_s.wr = 1'b1;
        next_s.fsm = nvm_ctrl_pkg::ST_ERASE;
        next_s.mem_valid = 1'b1;
        next_s.mem_op = nvm_ctrl_pkg::MEM_ERASE_ROW;
      end
      else
      begin
        next_s.wr = 1'b1;
        next_s.fsm = nvm_ctrl_pkg::ST_PROG;
        next_s.index = '0;
        next_s.mem_valid = 1'b1;
        next_s.mem_op = nvm_ctrl_pkg::MEM_PROGRAM_WORD;
      end
    end

    unique case (s.fsm)
      nvm_ctrl_pkg::ST_IDLE:
      begin
      end
      nvm_ctrl_pkg::ST_READ:
      begin
        if (mem_ready)
        begin
          // eeprom reads only fill the low byte
          if (eeprom_hit)
          begin
            next_s.value[7:0] = mem_rdata[7:0];
          end
          else
          begin
            next_s.value = mem_rdata;
          end
          next_s.rd = 1'b0;
          next_s.mem_valid = 1'b0;
          next_s.fsm = nvm_ctrl_pkg::ST_IDLE;
        end
      end
      nvm_ctrl_pkg::ST_ERASE, nvm_ctrl_pkg::ST_EEPROM:
      begin
        if (mem_ready)
        begin
          next_s.wr = 1'b0;
          next_s.mem_valid = 1'b0;
          next_s.fsm = nvm_ctrl_pkg::ST_IDLE;
        end
      end
      nvm_ctrl_pkg::ST_PROG:
      begin
        if (mem_ready)
        begin
          next_s.index = s.index + 1'b1;
          if (s.index == IDX_W'(ROW_WORDS - 1))
          begin
            latch_blank = 1'b1;
            next_s.wr = 1'b0;
            next_s.mem_valid = 1'b0;
            next_s.fsm = nvm_ctrl_pkg::ST_IDLE;
          end
        end
      end
      default:
      begin
        next_s.fsm = nvm_ctrl_pkg::ST_IDLE;
        next_s.mem_valid = 1'b0;
      end
    endcase

    // hardware sets win over a software clear in the same cycle
    if (unlock_broken)
    begin
      next_s.error = 1'b1;
    end
    if (s.after_reset && mem_busy)
    begin
      next_s.error = 1'b1;
    end

    // read data is captured in the setup phase, shown in the access phase
    next_s.prdata = '0;
    if (psel && !penable && !pwrite)
    begin
      if (hit_pointer)
      begin
        next_s.prdata = {16'h0000, s.wr, s.pointer};
      end
      else if (hit_value)
      begin
        next_s.prdata = {18'h00000, s.value};
      end
      else if (hit_control)
      begin
        next_s.prdata = {24'h000000, 1'b0, s.region, s.latch_only, s.free,
                         s.error, s.enable, s.wr, s.rd};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '{
        fsm: nvm_ctrl_pkg::ST_IDLE,
        pointer: `NVM_POINTER_RST,
        value: `NVM_VALUE_RST,
        region: 1'b0,
        latch_only: 1'b0,
        free: 1'b0,
        error: 1'b0,
        enable: 1'b0,
        wr: 1'b0,
        rd: 1'b0,
        index: '0,
        mem_valid: 1'b0,
        mem_op: nvm_ctrl_pkg::MEM_READ,
        after_reset: 1'b1,
        prdata: 32'h00000000
      };
    end
    else
    begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = s.prdata;
  assign mem_valid = s.mem_valid;
  assign mem_op = s.mem_op;
  assign mem_region = s.region;

  always_comb
  begin
    mem_addr = s.pointer;
    mem_wdata = s.value;
    if (s.fsm == nvm_ctrl_pkg::ST_ERASE)
    begin
      mem_addr = {s.pointer[14:IDX_W], IDX_W'(0)};
    end
    else if (s.fsm == nvm_ctrl_pkg::ST_PROG)
    begin
      mem_addr = {s.pointer[14:IDX_W], s.index};
      mem_wdata = latch_word;
    end
  end

endmodule : nvm_write_erase_control

//--- testbench/nvm_write_erase_control_assertions.sv
`timescale 1ns/1ps
module nvm_write_erase_control_assertions #(
  parameter int ROW_WORDS = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mem_valid,
  input wire nvm_ctrl_pkg::mem_op_e mem_op,
  input wire logic mem_region,
  input wire logic [14:0] mem_addr,
  input wire logic [13:0] mem_wdata,
  input wire logic mem_ready,
  input wire logic [13:0] mem_rdata,
  input wire logic mem_busy,
  input wire logic write_protected
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic ctl_wr;
  // only idle-time control writes can start anything
  assign ctl_wr = psel && penable && pwrite && paddr == 14'h2078 && pstrb[0] && !mem_valid;
  //////////////////////////////////////////////////////////////////////////////
  chk_request_hold:
    assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_op) && $stable(mem_addr))
    else $error("memory request changed before ready");
  chk_erase_row_base:
    assert property (mem_valid && mem_op == nvm_ctrl_pkg::MEM_ERASE_ROW |-> mem_addr[4:0] == 5'h00)
    else $error("erase address not a row base");
  chk_prog_first_word:
    assert property ($rose(mem_valid) && mem_op == nvm_ctrl_pkg::MEM_PROGRAM_WORD
      |-> mem_addr[4:0] == 5'h00)
    else $error("row program does not start at word 0");
  chk_prog_next_word:
    assert property (mem_valid && mem_ready && mem_op == nvm_ctrl_pkg::MEM_PROGRAM_WORD
      && mem_addr[4:0] != 5'h1F |=> mem_valid && mem_addr == $past(mem_addr) + 15'h0001)
    else $error("row program word order broken");
  chk_protect_no_req:
    assert property (ctl_wr && pwdata[1] && write_protected |=> !mem_valid [*2])
    else $error("protected trigger reached memory");
  chk_enable_gates:
    assert property (ctl_wr && pwdata[1] && !pwdata[2] && !pwdata[0] |=> !mem_valid [*2])
    else $error("trigger without enable reached memory");
  chk_latch_no_access:
    assert property (ctl_wr && pwdata[1] && !pwdata[4] && pwdata[5] && !pwdata[6]
      |=> !mem_valid [*2])
    else $error("latch load reached memory");
  chk_read_starts:
    assert property (ctl_wr && pwdata[0] && !pwdata[1]
      |=> mem_valid && mem_op == nvm_ctrl_pkg::MEM_READ)
    else $error("read bit did not start a read");
  chk_eeprom_target:
    assert property (mem_valid && mem_op == nvm_ctrl_pkg::MEM_EEPROM_WRITE
      |-> mem_region && mem_addr[14:8] == 7'h70)
    else $error("eeprom cycle outside eeprom page");
endmodule : nvm_write_erase_control_assertions

//--- testbench/testbench.sv
`timescale 1ns/1ps
`define CHECK(a, b) \
  begin \
    checked++; \
    if ((a) !== (b)) \
    begin \
      errors++; \
      $display("Error at %0t: %h not %h", $time, a, b); \
    end \
  end
module testbench;
  localparam logic [13:0] A_PTR = 14'h2068;
  localparam logic [13:0] A_VAL = 14'h2070;
  localparam logic [13:0] A_CTL = 14'h2078;
  localparam logic [13:0] A_KEY = 14'h207C;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic mem_valid, mem_region, mem_ready, mem_busy, write_protected, stall, last_region, last_err;
  logic [13:0] paddr, mem_wdata, mem_rdata, rd_word;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [14:0] mem_addr, last_addr;
  nvm_ctrl_pkg::mem_op_e mem_op, last_op;
  logic [13:0] got [32];
  int errors, checked, hs, hs0, cycles;

  nvm_write_erase_control #(.ROW_WORDS(32)) DUT (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .mem_valid, .mem_op, .mem_region,
    .mem_addr, .mem_wdata, .mem_ready, .mem_rdata, .mem_busy, .write_protected);

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  // memory side: answers every other cycle unless stalled
  always @(posedge pclk)
  begin
    mem_ready <= mem_valid && !mem_ready && !stall;
    mem_rdata <= (mem_valid && mem_op == nvm_ctrl_pkg::MEM_READ) ? rd_word : ~rd_word;
    if (mem_valid && mem_ready)
    begin
      hs++;
      got[mem_addr[4:0]] = mem_wdata;
      last_op = mem_op;
      last_addr = mem_addr;
      last_region = mem_region;
    end
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      give_verdict();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic [13:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the bench timeout ends a wait for the slave
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 4'hF);
  endtask : wr

  task automatic rdr(input logic [13:0] a);
    apb(a, 1'b0, 32'h0, 4'h0);
  endtask : rdr

  task automatic trig(input logic [7:0] c);
    hs0 = hs;
    wr(A_KEY, 32'h55);
    wr(A_KEY, 32'hAA);
    wr(A_CTL, {24'h0, c});
  endtask : trig

  task automatic wait_idle;
    do
    begin
      rdr(A_CTL);
    end
    while ((rd[1] | rd[0]) !== 1'b0);
  endtask : wait_idle
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rdr(A_CTL);
    `CHECK(rd[7:0], 8'h00)
    wr(A_PTR, 32'hFFFF);
    rdr(A_PTR);
    `CHECK(rd[15:0], 16'h7FFF)
    apb(A_PTR, 1'b1, 32'h0012, 4'h1);
    apb(A_PTR, 1'b1, 32'h0300, 4'h2);
    rdr(A_PTR);
    `CHECK(rd[15:0], 16'h0312)
    apb(A_VAL, 1'b1, 32'hFFFF, 4'h2);
    rdr(A_VAL);
    `CHECK(rd[15:0], 16'h3F00)
    rdr(14'h2000);
    `CHECK(last_err, 1'b1)
    $display("register test done");
  endtask : t_regs

  task automatic t_read;
    rd_word = 14'h1234;
    wr(A_PTR, 32'h0042);
    wr(A_CTL, 32'h01);
    wait_idle();
    rdr(A_VAL);
    `CHECK(rd[13:0], 14'h1234)
    $display("read test done");
  endtask : t_read

  task automatic t_latch_prog;
    wr(A_PTR, 32'h0143);
    wr(A_VAL, 32'h0155);
    trig(8'h26);
    wait_idle();
    `CHECK(hs, hs0)
    trig(8'h06);
    wait_idle();
    `CHECK(hs - hs0, 32)
    `CHECK(got[3], 14'h0155)
    `CHECK(got[4], 14'h03FF)
    `CHECK(last_addr, 15'h015F)
    // read back the programmed word through the read path
    rd_word = got[3];
    wr(A_CTL, 32'h01);
    wait_idle();
    rdr(A_VAL);
    `CHECK(rd[13:0], 14'h0155)
    trig(8'h06);
    wait_idle();
    `CHECK(got[3], 14'h03FF)
    $display("latch and program test done");
  endtask : t_latch_prog

  task automatic t_erase;
    wr(A_PTR, 32'h0127);
    stall <= 1'b1;
    trig(8'h16);
    rdr(A_CTL);
    `CHECK(rd[1], 1'b1)
    rdr(A_PTR);
    `CHECK(rd[15], 1'b1)
    stall <= 1'b0;
    wait_idle();
    `CHECK(last_op, nvm_ctrl_pkg::MEM_ERASE_ROW)
    `CHECK(last_addr, 15'h0120)
    trig(8'h12);
    wait_idle();
    `CHECK(hs, hs0)
    $display("erase test done");
  endtask : t_erase

  task automatic t_error;
    write_protected <= 1'b1;
    trig(8'h16);
    rdr(A_CTL);
    `CHECK(rd[3:1], 3'h6)
    write_protected <= 1'b0;
    `CHECK(hs, hs0)
    wr(A_CTL, 32'h0);
    rdr(A_CTL);
    `CHECK(rd[3], 1'b0)
    wr(A_CTL, 32'h08);
    rdr(A_CTL);
    `CHECK(rd[3], 1'b1)
    wr(A_CTL, 32'h0);
    wr(A_KEY, 32'h55);
    wr(A_PTR, 32'h0);
    rdr(A_CTL);
    `CHECK(rd[3], 1'b1)
    wr(A_CTL, 32'h0);
    hs0 = hs;
    wr(A_CTL, 32'h16);
    wait_idle();
    `CHECK(hs, hs0)
    wr(A_CTL, 32'h0);
    $display("error flag test done");
  endtask : t_error

  task automatic t_eeprom;
    wr(A_PTR, 32'h7005);
    trig(8'h46);
    wait_idle();
    `CHECK(last_op, nvm_ctrl_pkg::MEM_EEPROM_WRITE)
    `CHECK({last_region, last_addr}, 16'hF005)
    // eeprom reads replace only the low byte of the value
    wr(A_VAL, 32'h1100);
    rd_word = 14'h2A5C;
    wr(A_CTL, 32'h41);
    wait_idle();
    rdr(A_VAL);
    `CHECK(rd[13:0], 14'h115C)
    $display("eeprom test done");
  endtask : t_eeprom

  task automatic t_reset_busy;
    mem_busy <= 1'b1;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    mem_busy <= 1'b0;
    @(posedge pclk);
    rdr(A_CTL);
    `CHECK(rd[3], 1'b1)
    $display("reset while busy test done");
  endtask : t_reset_busy

  task automatic give_verdict;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {presetn, psel, penable, pwrite, mem_busy, write_protected, stall} = 7'h00;
    {paddr, pwdata, pstrb, rd_word} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_read();
    t_latch_prog();
    t_erase();
    t_error();
    t_eeprom();
    t_reset_busy();
    give_verdict();
  end
endmodule : testbench

bind nvm_write_erase_control nvm_write_erase_control_assertions #(.ROW_WORDS(ROW_WORDS)) u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
  .pslverr, .mem_valid, .mem_op, .mem_region, .mem_addr, .mem_wdata, .mem_ready, .mem_rdata,
  .mem_busy, .write_protected);
